//--- hdl/lcd_bias_sequencer_supervisor.sv
/*
  Sequencer and fault supervisor for an LCD bias supply: converter enables,
  start-up current limits, latched fault shutdown, panel reset and shifter modes.
  Assumes all flags are asynchronous comparator outputs and the clock runs freely.
*/
`timescale 1ns/10ps
module lcd_bias_sequencer_supervisor #(
  parameter int unsigned NEG_START_LIMIT = bias_seq_pkg::NEG_START_CYCLES,
  parameter int unsigned POS_START_LIMIT = bias_seq_pkg::POS_START_CYCLES,
  parameter int unsigned UV_LIMIT        = bias_seq_pkg::UNDERVOLT_CYCLES,
  parameter int unsigned CHANNELS        = bias_seq_pkg::SHIFT_CHANNELS
) (
  input  wire logic                          clock,
  input  wire logic                          reset,
  input  wire bias_seq_pkg::flags_t          flags,
  input  wire logic [CHANNELS-1:0]           shift_in,
  output logic                               boost_en,
  output logic                               neg_pump_en,
  output logic                               pos_pump_en,
  output logic                               neg_pump_limit,
  output logic                               pos_pump_limit,
  output logic                               fault_latched,
  output logic                               panel_reset_out_n_o,
  output logic                               panel_reset_out_n_oe_n,
  output bias_seq_pkg::shift_mode_t          shift_mode,
  output logic [CHANNELS-1:0]                shift_out
);
  import bias_seq_pkg::*;

  if (CHANNELS < 1 || NEG_START_LIMIT < 1 || POS_START_LIMIT < 1 || UV_LIMIT < 1) begin : g_bad
    $error("lcd_bias_sequencer_supervisor: counts and channels must be at least 1");
  end

  localparam int unsigned TW = 32;

  // Three-stage synchronisers, change accepted when stages two and three agree
  logic [FLAG_COUNT-1:0] s1_reg;
  logic [FLAG_COUNT-1:0] s2_reg;
  logic [FLAG_COUNT-1:0] s3_reg;
  logic [FLAG_COUNT-1:0] flt_reg;
  logic [FLAG_COUNT-1:0] flt_next;
  logic [CHANNELS-1:0]   d1_reg;
  logic [CHANNELS-1:0]   d2_reg;
  logic [CHANNELS-1:0]   d3_reg;
  logic [CHANNELS-1:0]   din_reg;
  logic [CHANNELS-1:0]   din_next;

  assign flt_next = (s2_reg & s3_reg) | (flt_reg & (s2_reg | s3_reg));
  assign din_next = (d2_reg & d3_reg) | (din_reg & (d2_reg | d3_reg));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      flt_reg <= '0;
      d1_reg  <= '0;
      d2_reg  <= '0;
      d3_reg  <= '0;
      din_reg <= '0;
    end else begin
      s1_reg  <= flags;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      flt_reg <= flt_next;
      d1_reg  <= shift_in;
      d2_reg  <= d1_reg;
      d3_reg  <= d2_reg;
      din_reg <= din_next;
    end
  end

  flags_t f;
  assign f = flags_t'(flt_reg);

  // Qualified conditions
  wire lockout_w   = f.supply_lockout;
  wire enable_w    = f.enable;
  wire hold_off_w  = lockout_w || !enable_w;
  wire paused_w    = f.over_temp;

  seq_state_t state_reg;
  seq_state_t state_next;
  logic       neg_ok_reg;
  logic       neg_ok_next;
  logic       pos_ok_reg;
  logic       pos_ok_next;
  logic       pos_started_reg;
  logic       pos_started_next;
  logic [TW-1:0] neg_start_cnt_reg;
  logic [TW-1:0] pos_start_cnt_reg;
  logic [TW-1:0] neg_uv_cnt_reg;
  logic [TW-1:0] pos_uv_cnt_reg;

  function automatic logic [TW-1:0] timer_step(input logic run, input logic [TW-1:0] cnt);
    timer_step = !run ? '0 : (cnt == '1 ? cnt : cnt + TW'(1));
  endfunction

  function automatic logic timer_hit(input logic [TW-1:0] cnt, input int unsigned lim);
    timer_hit = (cnt >= TW'(lim));
  endfunction

  wire active_w     = (state_reg == ST_START || state_reg == ST_RUN) && !paused_w;
  wire pos_phase_w  = active_w && pos_started_reg;
  wire neg_limit_w  = active_w && !neg_ok_reg;
  wire pos_limit_w  = pos_phase_w && !pos_ok_reg;
  // Start-up timers: negative counts from boost power-good
  wire neg_st_run_w = neg_limit_w && f.boost_pgood && !f.neg_fb_below_794;
  wire pos_st_run_w = pos_limit_w && !f.pos_fb_above_124;
  wire neg_uv_run_w = active_w && neg_ok_reg && !f.neg_pgood;
  wire pos_uv_run_w = pos_phase_w && pos_ok_reg && !f.pos_pgood;

  wire neg_st_fail_w = timer_hit(neg_start_cnt_reg, NEG_START_LIMIT);
  wire pos_st_fail_w = timer_hit(pos_start_cnt_reg, POS_START_LIMIT);
  wire neg_uv_fail_w = timer_hit(neg_uv_cnt_reg, UV_LIMIT + 1);
  wire pos_uv_fail_w = timer_hit(pos_uv_cnt_reg, UV_LIMIT + 1);
  wire neg_short_w   = active_w && neg_ok_reg && f.neg_fb_above_850;
  wire pos_short_w   = pos_phase_w && pos_ok_reg && f.pos_fb_below_340;
  wire fault_w       = neg_st_fail_w || pos_st_fail_w || neg_uv_fail_w
                       || pos_uv_fail_w || neg_short_w || pos_short_w;

  always_comb begin
    state_next       = state_reg;
    neg_ok_next      = neg_ok_reg;
    pos_ok_next      = pos_ok_reg;
    pos_started_next = pos_started_reg;
    case (state_reg)
      ST_OFF: begin
        neg_ok_next      = 1'b0;
        pos_ok_next      = 1'b0;
        pos_started_next = 1'b0;
        if (!hold_off_w)
          state_next = ST_START;
      end
      ST_START, ST_RUN: begin
        if (hold_off_w) begin
          state_next = ST_OFF;
        end else if (fault_w) begin
          state_next = ST_LATCHED;
        end else if (paused_w) begin
          // Over-temperature: restart the whole sequence when it clears
          state_next       = ST_START;
          neg_ok_next      = 1'b0;
          pos_ok_next      = 1'b0;
          pos_started_next = 1'b0;
        end else begin
          if (f.boost_pgood)
            pos_started_next = 1'b1;
          if (f.neg_pgood && f.neg_fb_below_794)
            neg_ok_next = 1'b1;
          if (pos_started_reg && f.pos_pgood && f.pos_fb_above_124)
            pos_ok_next = 1'b1;
          if (neg_ok_reg && pos_ok_reg)
            state_next = ST_RUN;
        end
      end
      ST_LATCHED: begin
        // Only a supply or enable cycle clears the latch
        if (hold_off_w)
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg         <= ST_OFF;
      neg_ok_reg        <= 1'b0;
      pos_ok_reg        <= 1'b0;
      pos_started_reg   <= 1'b0;
      neg_start_cnt_reg <= '0;
      pos_start_cnt_reg <= '0;
      neg_uv_cnt_reg    <= '0;
      pos_uv_cnt_reg    <= '0;
    end else begin
      state_reg         <= state_next;
      neg_ok_reg        <= neg_ok_next;
      pos_ok_reg        <= pos_ok_next;
      pos_started_reg   <= pos_started_next;
      neg_start_cnt_reg <= timer_step(neg_st_run_w, neg_start_cnt_reg);
      pos_start_cnt_reg <= timer_step(pos_st_run_w, pos_start_cnt_reg);
      neg_uv_cnt_reg    <= timer_step(neg_uv_run_w, neg_uv_cnt_reg);
      pos_uv_cnt_reg    <= timer_step(pos_uv_run_w, pos_uv_cnt_reg);
    end
  end

  // Converter outputs, all off outside start and run or on over-temperature
  conv_ctrl_t ctrl_next;
  wire        go_w = active_w && (state_next == ST_START || state_next == ST_RUN);
  assign ctrl_next.boost_en       = go_w;
  assign ctrl_next.neg_pump_en    = go_w;
  assign ctrl_next.pos_pump_en    = go_w && pos_started_next;
  assign ctrl_next.neg_pump_limit = go_w && !neg_ok_next;
  assign ctrl_next.pos_pump_limit = go_w && pos_started_next && !pos_ok_next;

  // Panel detect: low before detect has ever been high goes to gate-off, low after it has been high to gate-on
  logic        powered_reg;
  logic        powered_next;
  shift_mode_t mode_next;
  wire         det_w = f.panel_detect_high;
  assign powered_next = det_w ? 1'b1 : powered_reg;
  assign mode_next    = det_w ? LS_PASS
                      : (powered_reg ? LS_GATE_ON : LS_GATE_OFF);

  function automatic logic [CHANNELS-1:0] shift_drive(input shift_mode_t m,
                                                     input logic [CHANNELS-1:0] d);
    case (m)
      LS_PASS:    shift_drive = d;
      LS_GATE_ON: shift_drive = '1;
      default:    shift_drive = '0;
    endcase
  endfunction

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      boost_en               <= 1'b0;
      neg_pump_en            <= 1'b0;
      pos_pump_en            <= 1'b0;
      neg_pump_limit         <= 1'b0;
      pos_pump_limit         <= 1'b0;
      fault_latched          <= 1'b0;
      powered_reg            <= 1'b0;
      panel_reset_out_n_o    <= 1'b0;
      panel_reset_out_n_oe_n <= 1'b0;
      shift_mode             <= LS_GATE_OFF;
      shift_out              <= '0;
    end else begin
      boost_en               <= ctrl_next.boost_en;
      neg_pump_en            <= ctrl_next.neg_pump_en;
      pos_pump_en            <= ctrl_next.pos_pump_en;
      neg_pump_limit         <= ctrl_next.neg_pump_limit;
      pos_pump_limit         <= ctrl_next.pos_pump_limit;
      fault_latched          <= (state_next == ST_LATCHED);
      powered_reg            <= powered_next;
      panel_reset_out_n_o    <= 1'b0;
      panel_reset_out_n_oe_n <= det_w;
      shift_mode             <= mode_next;
      shift_out              <= shift_drive(mode_next, din_next);
    end
  end
endmodule // lcd_bias_sequencer_supervisor

//--- include/bias_seq_pkg.sv
/*
  Constants, states and carrier types for the LCD bias sequencer and supervisor.
  Assumes a free-running 50 MHz core clock and comparator flags from the analog side.
*/
package bias_seq_pkg;
  localparam int unsigned CLOCK_HZ          = 50_000_000;
  localparam int unsigned NEG_START_MS      = 10;
  localparam int unsigned POS_START_MS      = 15;
  localparam int unsigned UNDERVOLT_MS      = 55;
  localparam int unsigned NEG_START_CYCLES  = CLOCK_HZ / 1000 * NEG_START_MS;
  localparam int unsigned POS_START_CYCLES  = CLOCK_HZ / 1000 * POS_START_MS;
  localparam int unsigned UNDERVOLT_CYCLES  = CLOCK_HZ / 1000 * UNDERVOLT_MS;
  localparam int unsigned SHIFT_CHANNELS    = 6;
  localparam int unsigned SYNC_STAGES       = 3;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_START   = 3'b001,
    ST_RUN     = 3'b010,
    ST_LATCHED = 3'b011
  } seq_state_t;

  typedef enum logic [1:0] {
    LS_PASS     = 2'b00,
    LS_GATE_OFF = 2'b01,
    LS_GATE_ON  = 2'b10
  } shift_mode_t;

  // Comparator flags from the analog side
  typedef struct packed {
    logic supply_lockout;
    logic enable;
    logic boost_pgood;
    logic neg_pgood;
    logic pos_pgood;
    logic neg_fb_below_794;
    logic neg_fb_above_850;
    logic pos_fb_above_124;
    logic pos_fb_below_340;
    logic panel_detect_high;
    logic over_temp;
  } flags_t;

  localparam int unsigned FLAG_COUNT = $bits(flags_t);

  typedef struct packed {
    logic boost_en;
    logic neg_pump_en;
    logic pos_pump_en;
    logic neg_pump_limit;
    logic pos_pump_limit;
  } conv_ctrl_t;
endpackage

//--- verif/analog_model.sv
/*
  Converters and comparators: power-good follows an enable after four cycles.
  Assumes cmd bits 0..5: neg stall, pos stall, neg short, pos short, neg droop, pos droop.
*/
`timescale 1ns/10ps
module analog_model (
  input wire logic       clock,
  input wire logic       boost_en,
  input wire logic       neg_en,
  input wire logic       pos_en,
  input wire logic [5:0] cmd,
  output logic           boost_pg,
  output logic           neg_pg,
  output logic           pos_pg,
  output logic           neg_low,
  output logic           neg_high,
  output logic           pos_up,
  output logic           pos_low
);
  logic [3:0] b_d, n_d, p_d;
  always_ff @(posedge clock) begin
    b_d <= {b_d[2:0], boost_en};
    n_d <= {n_d[2:0], neg_en};
    p_d <= {p_d[2:0], pos_en};
  end
  assign boost_pg = boost_en & b_d[3];
  assign neg_low  = neg_en & n_d[3] & ~cmd[0];
  assign neg_pg   = neg_low & ~cmd[4];
  assign neg_high = cmd[2];
  assign pos_up   = pos_en & p_d[3] & ~cmd[1];
  assign pos_pg   = pos_up & ~cmd[5];
  assign pos_low  = cmd[3];
endmodule // analog_model

//--- verif/bias_seq_asserts.sv
/*
  Concurrent checks on the sequencer's top-level ports.
  Assumes flags change slowly against the clock, as comparator levels do.
*/
`timescale 1ns/10ps
module bias_seq_asserts #(
  parameter int unsigned CHANNELS = 6
) (
  input wire logic                      clock,
  input wire logic                      reset,
  input wire bias_seq_pkg::flags_t      flags,
  input wire logic [CHANNELS-1:0]       shift_in,
  input wire logic                      boost_en,
  input wire logic                      neg_pump_en,
  input wire logic                      pos_pump_en,
  input wire logic                      neg_pump_limit,
  input wire logic                      pos_pump_limit,
  input wire logic                      fault_latched,
  input wire logic                      panel_reset_out_n_o,
  input wire logic                      panel_reset_out_n_oe_n,
  input wire bias_seq_pkg::shift_mode_t shift_mode,
  input wire logic [CHANNELS-1:0]       shift_out
);
  import bias_seq_pkg::*;
  wire off = !boost_en && !neg_pump_en && !pos_pump_en;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_pair; $rose(boost_en) |-> neg_pump_en && !pos_pump_en; endproperty
  a_pair: assert property (p_pair) else $error("boost start");
  property p_pos;
    $rose(pos_pump_en) |-> boost_en && neg_pump_en && $past(flags.boost_pgood, 3);
  endproperty
  a_pos: assert property (p_pos) else $error("pos pump start");
  property p_en_low; !flags.enable [*7] |=> off; endproperty
  a_en_low: assert property (p_en_low) else $error("enable low");
  property p_lock; flags.supply_lockout [*7] |=> off; endproperty
  a_lock: assert property (p_lock) else $error("lockout");
  property p_hot; flags.over_temp [*7] |=> off; endproperty
  a_hot: assert property (p_hot) else $error("over temp");
  property p_fault; fault_latched |-> off; endproperty
  a_fault: assert property (p_fault) else $error("fault not off");
  property p_pin;
    $stable(flags.panel_detect_high) [*7]
      |-> panel_reset_out_n_oe_n == flags.panel_detect_high && !panel_reset_out_n_o;
  endproperty
  a_pin: assert property (p_pin) else $error("reset pin");
  property p_pass;
    (shift_mode == LS_PASS && $stable(shift_in)) [*7] |-> shift_out == shift_in;
  endproperty
  a_pass: assert property (p_pass) else $error("shift pass");
  property p_goff; shift_mode == LS_GATE_OFF [*2] |-> shift_out == '0; endproperty
  a_goff: assert property (p_goff) else $error("gate off");
  property p_gon; shift_mode == LS_GATE_ON [*2] |-> shift_out == '1; endproperty
  a_gon: assert property (p_gon) else $error("gate on");
  property p_nshort;
    $rose(flags.neg_fb_above_850) && neg_pump_en && !neg_pump_limit |-> ##[3:8] fault_latched;
  endproperty
  a_nshort: assert property (p_nshort) else $error("neg short");
  property p_pshort;
    $rose(flags.pos_fb_below_340) && pos_pump_en && !pos_pump_limit |-> ##[3:8] fault_latched;
  endproperty
  a_pshort: assert property (p_pshort) else $error("pos short");
  c_fault: cover property ($rose(fault_latched));
  c_pos: cover property ($rose(pos_pump_en));
  c_gon: cover property (shift_mode == LS_GATE_ON);
endmodule // bias_seq_asserts

//--- verif/tb_top.sv
/*
  Scenario testbench for the bias sequencer with short fault timers.
  Assumes the analog model answers the converter enables.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("BAD %s exp %h got %h", n, e, g); \
  end end
module tb_top;
  import bias_seq_pkg::*;
  logic             clock = 1'b0, reset = 1'b1;
  logic             lock = 1'b0, en = 1'b0, det = 1'b0, ot = 1'b0;
  logic [5:0]       cmd = 6'h00;
  logic [5:0]       shift_in = 6'h2a;
  logic             bpg, npg, ppg, nlow, nhigh, pup, plow;
  logic             boost_en, neg_pump_en, pos_pump_en, nlim, plim, fault, rst_o, oe_n;
  shift_mode_t      mode;
  logic [5:0]       sout;
  int               num_errors = 0;
  int               cmp_count = 0;
  wire flags_t      flags = {lock, en, bpg, npg, ppg, nlow, nhigh, pup, plow, det, ot};
  wire logic [2:0]  ens = {boost_en, neg_pump_en, pos_pump_en};
  always #10 clock = ~clock;
  lcd_bias_sequencer_supervisor #(.NEG_START_LIMIT(20), .POS_START_LIMIT(30),
    .UV_LIMIT(50), .CHANNELS(6)) dut (.clock(clock), .reset(reset), .flags(flags),
    .shift_in(shift_in), .boost_en(boost_en), .neg_pump_en(neg_pump_en),
    .pos_pump_en(pos_pump_en), .neg_pump_limit(nlim), .pos_pump_limit(plim),
    .fault_latched(fault), .panel_reset_out_n_o(rst_o), .panel_reset_out_n_oe_n(oe_n),
    .shift_mode(mode), .shift_out(sout));
  analog_model model (.clock(clock), .boost_en(boost_en), .neg_en(neg_pump_en),
    .pos_en(pos_pump_en), .cmd(cmd), .boost_pg(bpg), .neg_pg(npg), .pos_pg(ppg),
    .neg_low(nlow), .neg_high(nhigh), .pos_up(pup), .pos_low(plow));
  task automatic w(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic give_verdict;
    if (num_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_start;
    w(10);
    `CHK("ens", 3'h0, ens)
    `CHK("mode", LS_GATE_OFF, mode)
    `CHK("sout", 6'h00, sout)
    `CHK("oe_n", 2'h0, {oe_n, rst_o})
    en = 1'b1;
    w(8);
    `CHK("ens", 3'h6, ens)
    `CHK("nlim", 1'b1, nlim)
    w(10);
    `CHK("plim", 1'b1, plim)
    w(30);
    `CHK("ens", 3'h7, ens)
    `CHK("lims", 2'h0, {nlim, plim})
  endtask
  task automatic t_panel;
    det = 1'b1;
    w(8);
    `CHK("mode", LS_PASS, mode)
    shift_in = 6'h15;
    w(8);
    `CHK("sout", 6'h15, sout)
    lock = 1'b1;
    w(8);
    `CHK("ens", 3'h0, ens)
    `CHK("oe_n", 1'b1, oe_n)
    det = 1'b0;
    w(8);
    `CHK("oe_n", 1'b0, oe_n)
    `CHK("sout", 6'h3f, sout)
    lock = 1'b0;
    w(40);
    `CHK("ens", 3'h7, ens)
  endtask
  task automatic t_hot;
    ot = 1'b1;
    w(8);
    `CHK("ens", 3'h0, ens)
    ot = 1'b0;
    w(40);
    `CHK("ens", 3'h7, ens)
    repeat (2) begin
      cmd[4] = 1'b1;
      w(30);
      cmd[4] = 1'b0;
      w(10);
    end
    `CHK("fault", 1'b0, fault)
  endtask
  task automatic t_faults;
    int e[6] = '{20, 30, 2, 2, 40, 40};
    int l[6] = '{30, 50, 8, 8, 35, 35};
    for (int i = 0; i < 6; i++) begin
      en = 1'b0;
      w(8);
      `CHK("ens", 3'h0, ens)
      en = 1'b1;
      if (i > 1) w(40);
      cmd[i] = 1'b1;
      w(e[i]);
      `CHK("early", 1'b0, fault)
      w(l[i]);
      `CHK("fault", 4'h8, {fault, ens})
      cmd[i] = 1'b0;
      w(10);
      `CHK("held", 1'b1, fault)
    end
    en = 1'b0;
    w(8);
    en = 1'b1;
    w(40);
    `CHK("again", 4'h7, {fault, ens})
  endtask
  initial begin
    w(16);
    reset = 1'b0;
    t_start();
    t_panel();
    t_hot();
    t_faults();
    give_verdict();
  end
  initial begin
    repeat (6000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
endmodule // tb_top
bind lcd_bias_sequencer_supervisor bias_seq_asserts #(.CHANNELS(CHANNELS)) chk (
  .clock(clock), .reset(reset), .flags(flags), .shift_in(shift_in), .boost_en(boost_en),
  .neg_pump_en(neg_pump_en), .pos_pump_en(pos_pump_en), .neg_pump_limit(neg_pump_limit),
  .pos_pump_limit(pos_pump_limit), .fault_latched(fault_latched),
  .panel_reset_out_n_o(panel_reset_out_n_o), .panel_reset_out_n_oe_n(panel_reset_out_n_oe_n),
  .shift_mode(shift_mode), .shift_out(shift_out));
